// ==== verilog/cpirq_router.sv ====
// cpirq_router: peripheral routing, core prioritiser and interrupt stacks
module cpirq_router (
   input  wire logic                   clock,
   input  wire logic                   sys_rst,
   input  wire logic [31:0]            periph_irq,
   input  wire logic                   emu_irq,
   input  wire logic                   soft_reset_irq,
   input  wire logic                   pwrdn_irq,
   input  wire logic                   kernel_irq,
   input  wire logic                   global_irq_enable_instr,
   input  wire logic                   global_irq_disable_instr,
   input  wire logic                   irq_accept,
   input  wire logic                   irq_return,
   input  wire logic [23:0]            core_pc,
   input  wire logic [15:0]            core_status,
   input  wire logic                   pc_push,
   input  wire logic                   pc_pop,
   input  wire logic                   loop_push,
   input  wire logic                   loop_pop,
   input  wire logic [23:0]            loop_data,
   input  wire cpirq_pkg::cpirq_reg_req_t reg_req,
   output cpirq_pkg::cpirq_vec_t       irq_out,
   output logic                        emu_request,
   output logic [15:0]                 reg_rdata,
   output logic [23:0]                 pc_top,
   output logic [23:0]                 loop_top,
   output logic [15:0]                 status_restore
);

   // lowest set bit of a vector, i.e. the highest priority one
   function automatic logic [4:0] first_set(input logic [15:0] v);
      logic [4:0] r;
      r = 5'h10;
      for (int i = 15; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b0, 4'(i)};
         end
      end
      return r;
   endfunction : first_set

   logic [15:0] route [cpirq_pkg::N_ROUTE_REG];   // slot code registers
   logic [15:0] core_irq_mask;                     // per-bit enables
   logic [15:0] core_irq_latch;                    // pending requests
   logic [15:0] irq_nesting_control;               // nest and global enable
   logic [15:0] in_service;                        // handlers running
   logic [11:0] slot_req;                          // routed slot levels
   logic [15:0] set_bits;                          // hardware set events
   logic [15:0] clr_bits;                          // accepted bit clear
   logic [15:0] eff;                               // masked and gated
   logic [4:0]  sel;                               // chosen index
   logic [4:0]  svc;                               // top in-service index
   logic        grant;                             // selection may go out
   logic        take;                              // accept is valid
   logic        stack_evt;                         // pc mark crossed

   // pc stack storage and depth
   logic [23:0] pc_mem [cpirq_pkg::PC_LEVELS];
   logic [5:0]  pc_depth;
   logic [5:0]  next_pc_depth;
   logic        pc_do_push;
   logic        pc_do_pop;
   // loop and status stacks
   logic [23:0] loop_mem [cpirq_pkg::LOOP_LEVELS];
   logic [3:0]  loop_depth;
   logic [15:0] stat_mem [cpirq_pkg::STAT_LEVELS];
   logic [4:0]  stat_depth;

   wire logic wr_en = reg_req.wr;                  // write strobe
   wire logic rd_en = reg_req.rd;                  // read strobe

   // peripheral routing: each source ORs into the slot its code names
   always_comb begin
      logic [3:0] code;
      code     = 4'h0;
      slot_req = 12'h000;
      for (int p = 0; p < cpirq_pkg::N_PERIPH; p++) begin
         // register p/4, nibble p%4 from the bottom
         code = route[p / 4][(p % 4) * cpirq_pkg::CODE_W +: 4];
         if (code <= cpirq_pkg::CODE_LAST) begin
            slot_req[code] = slot_req[code] | periph_irq[p];
         end
         // codes above 0xB drive nothing
      end
   end

   // route code registers, all disabled out of reset
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         for (int r = 0; r < cpirq_pkg::N_ROUTE_REG; r++) begin
            route[r] <= cpirq_pkg::RST_ROUTE;
         end
      end else if (wr_en && reg_req.idx[3]) begin
         route[reg_req.idx[2:0]] <= reg_req.wdata;
      end
   end

   // mask register, everything masked out of reset
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         core_irq_mask <= cpirq_pkg::RST_MASK;
      end else if (wr_en && reg_req.idx == cpirq_pkg::IDX_MASK) begin
         core_irq_mask <= reg_req.wdata;
      end
   end

   // control: instructions override a same-cycle register write
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         irq_nesting_control <= cpirq_pkg::RST_CONTROL;
      end else begin
         if (wr_en && reg_req.idx == cpirq_pkg::IDX_CONTROL) begin
            irq_nesting_control <= reg_req.wdata;
         end
         if (global_irq_enable_instr) begin
            irq_nesting_control[cpirq_pkg::CTL_GIE] <= 1'b1;
         end else if (global_irq_disable_instr) begin
            irq_nesting_control[cpirq_pkg::CTL_GIE] <= 1'b0;
         end
      end
   end

   // hardware events feeding the latch
   always_comb begin
      set_bits = 16'h0000;
      set_bits[cpirq_pkg::BIT_RESET]  = soft_reset_irq;
      set_bits[cpirq_pkg::BIT_PWRDN]  = pwrdn_irq;
      set_bits[cpirq_pkg::BIT_STACK]  = stack_evt;
      set_bits[cpirq_pkg::BIT_KERNEL] = kernel_irq;
      set_bits[15:cpirq_pkg::BIT_USER0] = slot_req;
      clr_bits = 16'h0000;
      if (take) begin
         clr_bits[irq_out.index] = 1'b1;
      end
   end

   // latch: a hardware set always beats a clear or a write
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         core_irq_latch <= cpirq_pkg::RST_LATCH;
      end else if (wr_en && reg_req.idx == cpirq_pkg::IDX_LATCH) begin
         core_irq_latch <= reg_req.wdata | set_bits;
      end else begin
         core_irq_latch <= (core_irq_latch & ~clr_bits) | set_bits;
      end
   end

   // selection: mask, global gate, then priority and nesting
   always_comb begin
      eff = core_irq_latch &
            (core_irq_mask | cpirq_pkg::MASK_BYPASS);
      if (!irq_nesting_control[cpirq_pkg::CTL_GIE]) begin
         eff = eff & cpirq_pkg::GIE_BYPASS;
      end
      sel = first_set(eff);
      svc = first_set(in_service);
      grant = 1'b0;
      if (!sel[4]) begin
         if (in_service == 16'h0000 || sel[3:0] == 4'h0) begin
            grant = 1'b1;
         end else if (irq_nesting_control[cpirq_pkg::CTL_NEST]) begin
            grant = (sel < svc);
         end
      end
   end

   assign take = irq_accept && irq_out.valid;

   // request to the sequencer; drops for the cycle after an accept so a
   // just-cleared bit is never offered twice
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         irq_out <= '0;
      end else begin
         irq_out.valid  <= grant && !take;
         irq_out.index  <= sel[3:0];
         irq_out.vector <= 24'({sel[3:0], 5'h00});
      end
   end

   // emulator request bypasses latch, mask and enable; it has no vector
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         emu_request <= 1'b0;
      end else begin
         emu_request <= emu_irq;
      end
   end

   // in-service set: entry marks, return frees the highest running one
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         in_service <= 16'h0000;
      end else begin
         if (irq_return && !svc[4]) begin
            in_service[svc[3:0]] <= 1'b0;
         end
         if (take) begin
            in_service[irq_out.index] <= 1'b1;
         end
      end
   end

   // pc stack control; push and pop together cancel out
   always_comb begin
      pc_do_push = (take || pc_push) && !(irq_return || pc_pop);
      pc_do_pop  = (irq_return || pc_pop) && !(take || pc_push);
      next_pc_depth = pc_depth;
      if (pc_do_push && pc_depth < 6'(cpirq_pkg::PC_LEVELS)) begin
         next_pc_depth = pc_depth + 6'h01;
      end else if (pc_do_pop && pc_depth != 6'h00) begin
         next_pc_depth = pc_depth - 6'h01;
      end
      // only a crossing raises it, not a depth that merely sits low
      stack_evt = (pc_depth >= cpirq_pkg::PC_LOW_MARK &&
                   next_pc_depth < cpirq_pkg::PC_LOW_MARK) ||
                  (pc_depth <= cpirq_pkg::PC_HIGH_MARK &&
                   next_pc_depth > cpirq_pkg::PC_HIGH_MARK);
   end

   // pc stack storage; overflow pushes are dropped
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pc_depth <= 6'h00;
         pc_top   <= 24'h00_0000;
      end else begin
         pc_depth <= next_pc_depth;
         if (pc_do_push && pc_depth < 6'(cpirq_pkg::PC_LEVELS)) begin
            pc_mem[pc_depth] <= core_pc;
         end else if (pc_do_pop && pc_depth != 6'h00) begin
            pc_top <= pc_mem[pc_depth - 6'h01];
         end
      end
   end

   // status stack, saved on entry and restored on return
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         stat_depth     <= 5'h00;
         status_restore <= 16'h0000;
      end else if (take && !irq_return) begin
         if (stat_depth < 5'(cpirq_pkg::STAT_LEVELS)) begin
            stat_mem[stat_depth[3:0]] <= core_status;
            stat_depth <= stat_depth + 5'h01;
         end
      end else if (irq_return && !take && stat_depth != 5'h00) begin
         status_restore <= stat_mem[4'(stat_depth - 5'h01)];
         stat_depth     <= stat_depth - 5'h01;
      end
   end

   // loop stack, driven by the sequencer
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         loop_depth <= 4'h0;
         loop_top   <= 24'h00_0000;
      end else if (loop_push && !loop_pop) begin
         if (loop_depth < 4'(cpirq_pkg::LOOP_LEVELS)) begin
            loop_mem[loop_depth[2:0]] <= loop_data;
            loop_depth <= loop_depth + 4'h1;
         end
      end else if (loop_pop && !loop_push && loop_depth != 4'h0) begin
         loop_top   <= loop_mem[3'(loop_depth - 4'h1)];
         loop_depth <= loop_depth - 4'h1;
      end
   end

   // read port; unmapped indices answer zero
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 16'h0000;
      end else if (rd_en) begin
         if (reg_req.idx[3]) begin
            reg_rdata <= route[reg_req.idx[2:0]];
         end else begin
            unique case (reg_req.idx)
               cpirq_pkg::IDX_MASK:    reg_rdata <= core_irq_mask;
               cpirq_pkg::IDX_LATCH:   reg_rdata <= core_irq_latch;
               cpirq_pkg::IDX_CONTROL: reg_rdata <= irq_nesting_control;
               cpirq_pkg::IDX_STACKS:  reg_rdata <= {1'b0, stat_depth,
                                                     loop_depth, pc_depth};
               default:                reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

endmodule : cpirq_router

// ==== common/cpirq_pkg.sv ====
// cpirq_pkg: constants, register indices and carrier types of the irq router
// Summary of operation
// - route thirty-two peripheral requests toward core
// - each source owns a four-bit slot code
// - eight sixteen-bit code registers, four codes each
// - codes 0x0..0xB select same-numbered user slot
// - codes 0xC..0xF leave the request unconnected
// - shared slot requested while any source active
// - after reset every source is unrouted
// - fixed order: emulator, then latch bits 0..15
// - vector equals latch index times 0x20
// - latch ANDed with mask, lowest-numbered survivor chosen
// - reset, power-down ignore mask; disable blocks power-down
// - control register holds nesting and global enable
// - software writes force or clear latch bits
// - global enable/disable beat a same-cycle control write
// - servicing disabled after reset, except the soft reset request
// - stacks: 33 pc, 8 loop, 16 status levels
// - stack interrupt below 3 or above 28 entries
package cpirq_pkg;
   localparam int N_PERIPH     = 32;        // peripheral request inputs
   localparam int N_SLOT       = 12;        // user-assignable core slots
   localparam int N_ROUTE_REG  = 8;         // code registers
   localparam int CODE_W       = 4;         // routing code width
   localparam int REG_W        = 16;        // register width
   localparam int ADDR_W       = 24;        // program address width
   localparam int PC_LEVELS    = 33;        // pc stack depth
   localparam int LOOP_LEVELS  = 8;         // loop stack depth
   localparam int STAT_LEVELS  = 16;        // status stack depth
   localparam logic [5:0] PC_LOW_MARK  = 6'h03;  // below this: interrupt
   localparam logic [5:0] PC_HIGH_MARK = 6'h1C;  // above this: interrupt
   // latch bit positions
   localparam int BIT_RESET    = 0;
   localparam int BIT_PWRDN    = 1;
   localparam int BIT_STACK    = 2;
   localparam int BIT_KERNEL   = 3;
   localparam int BIT_USER0    = 4;
   localparam logic [15:0] MASK_BYPASS = 16'h0003; // reset and power-down
   localparam logic [15:0] GIE_BYPASS  = 16'h0001; // only reset passes
   localparam logic [4:0]  VEC_STEP_SH = 5'h05;    // 0x20 per index
   // register indices on the core access port
   localparam logic [3:0] IDX_MASK    = 4'h0;
   localparam logic [3:0] IDX_LATCH   = 4'h1;
   localparam logic [3:0] IDX_CONTROL = 4'h2;
   localparam logic [3:0] IDX_STACKS  = 4'h3;     // read only depths
   localparam logic [3:0] IDX_ROUTE0  = 4'h8;     // 0x8..0xF route codes
   // control register fields
   localparam int CTL_NEST     = 0;
   localparam int CTL_GIE      = 5;
   // reset values
   localparam logic [15:0] RST_MASK    = 16'h0000;
   localparam logic [15:0] RST_LATCH   = 16'h0000;
   localparam logic [15:0] RST_CONTROL = 16'h0000;
   localparam logic [15:0] RST_ROUTE   = 16'hFFFF;
   localparam logic [3:0]  CODE_LAST   = 4'hB;    // highest valid code

   typedef struct packed {
      logic        wr;      // write strobe
      logic        rd;      // read strobe
      logic [3:0]  idx;     // register index
      logic [15:0] wdata;   // write data
   } cpirq_reg_req_t;

   typedef struct packed {
      logic        valid;   // request to the sequencer
      logic [3:0]  index;   // latch bit being requested
      logic [23:0] vector;  // service address
   } cpirq_vec_t;
endpackage : cpirq_pkg

// ==== tb/cpirq_router_checker.sv ====
// cpirq_router_checker: port-level assertions for the irq router
module cpirq_router_checker (
   input wire logic                      clock,
   input wire logic                      sys_rst,
   input wire logic                      emu_irq,
   input wire logic                      soft_reset_irq,
   input wire logic                      global_irq_enable_instr,
   input wire logic                      global_irq_disable_instr,
   input wire logic                      irq_accept,
   input wire cpirq_pkg::cpirq_reg_req_t reg_req,
   input wire cpirq_pkg::cpirq_vec_t     irq_out,
   input wire logic                      emu_request,
   input wire logic [15:0]               reg_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   logic gie_q;   // shadow of the global enable bit
   // enable wins over disable when both pulse together
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) gie_q <= 1'b0;
      else if (global_irq_enable_instr) gie_q <= 1'b1;
      else if (global_irq_disable_instr) gie_q <= 1'b0;
      else if (reg_req.wr && reg_req.idx == cpirq_pkg::IDX_CONTROL)
         gie_q <= reg_req.wdata[cpirq_pkg::CTL_GIE];
   end
   sequence s_take;   // sequencer takes a presented request
      irq_out.valid && irq_accept;
   endsequence
   a_accept_drop: assert property (s_take |=> !irq_out.valid)
      else $error("request still presented after accept");
   a_valid_stands: assert property
      (irq_out.valid && !irq_accept |=> irq_out.valid)
      else $error("request withdrawn before accept");
   a_vec_index: assert property (irq_out.valid |->
      irq_out.vector == {15'h0000, irq_out.index, 5'h00})
      else $error("vector does not match index");
   a_emu_follow: assert property (emu_irq |=> emu_request)
      else $error("emulator request not passed on");
   a_reset_grant: assert property ($rose(soft_reset_irq) |->
      ##[1:3] (irq_out.valid && irq_out.index == 4'h0))
      else $error("reset interrupt not granted");
   a_gie_gate: assert property ($rose(irq_out.valid) &&
      irq_out.index != 4'h0 |-> $past(gie_q))
      else $error("request raised while globally disabled");
   a_rdata_stands: assert property
      (!reg_req.rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   a_hole_reads: assert property
      (reg_req.rd && reg_req.idx[3:2] == 2'b01 |=> reg_rdata == 16'h0000)
      else $error("unused index read back nonzero");
endmodule : cpirq_router_checker

bind cpirq_router cpirq_router_checker cpirq_router_checker_i (
   .clock(clock), .sys_rst(sys_rst), .emu_irq(emu_irq),
   .soft_reset_irq(soft_reset_irq), .irq_accept(irq_accept),
   .global_irq_enable_instr(global_irq_enable_instr),
   .global_irq_disable_instr(global_irq_disable_instr),
   .reg_req(reg_req), .irq_out(irq_out), .emu_request(emu_request),
   .reg_rdata(reg_rdata));

// ==== tb/cpirq_seq_model.sv ====
// cpirq_seq_model: behavioural core sequencer taking vectored requests
module cpirq_seq_model (
   input  wire logic                  clock,
   input  wire logic                  sys_rst,
   input  wire logic                  slow,
   input  wire cpirq_pkg::cpirq_vec_t irq_out,
   output logic                       irq_accept,
   output logic                       irq_return
);
   timeunit 1ns;
   timeprecision 1ns;
   int wait_n;   // cycles the request has waited
   int run_n;    // handler cycles left, 0 when idle
   // falling edge keeps pulses clear of the sampling edge
   always @(negedge clock or posedge sys_rst) begin
      irq_accept <= 1'b0;
      irq_return <= 1'b0;
      if (sys_rst) begin
         wait_n = 0;
         run_n = 0;
      end else if (run_n > 0) begin
         run_n = run_n - 1;
         if (run_n == 0) irq_return <= 1'b1;   // end of handler
      end else if (irq_out.valid === 1'b1) begin
         wait_n = wait_n + 1;
         // slow mode leaves the request standing several cycles
         if (wait_n > (slow ? 4 : 0)) begin
            irq_accept <= 1'b1;
            wait_n = 0;
            run_n = 3;
         end
      end
   end
endmodule : cpirq_seq_model

// ==== tb/core_and_peripheral_irq_router_test.sv ====
// core_and_peripheral_irq_router_test: self-checking bench of the router
module core_and_peripheral_irq_router_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clock, sys_rst, emu_irq, soft_reset_irq, pwrdn_irq;
   logic        gen_i, gdis_i, irq_accept, irq_return, slow;
   logic        pc_push, pc_pop, loop_push, loop_pop, kern, emu_request;
   logic [31:0] periph_irq;
   logic [23:0] core_pc, pc_top, loop_top;
   logic [15:0] core_status, reg_rdata, status_restore;
   cpirq_pkg::cpirq_reg_req_t req;
   cpirq_pkg::cpirq_vec_t     irq_out;
   int          failures, num_checks, seed, src, code, k;
   int          regs [16];   // model of register contents
   cpirq_router cpirq_router_i (
      .clock(clock), .sys_rst(sys_rst), .periph_irq(periph_irq),
      .emu_irq(emu_irq), .soft_reset_irq(soft_reset_irq),
      .pwrdn_irq(pwrdn_irq), .kernel_irq(kern),
      .global_irq_enable_instr(gen_i), .global_irq_disable_instr(gdis_i),
      .irq_accept(irq_accept), .irq_return(irq_return),
      .core_pc(core_pc), .core_status(core_status), .pc_push(pc_push),
      .pc_pop(pc_pop), .loop_push(loop_push), .loop_pop(loop_pop),
      .loop_data(core_pc), .reg_req(req), .irq_out(irq_out),
      .emu_request(emu_request), .reg_rdata(reg_rdata), .pc_top(pc_top),
      .loop_top(loop_top), .status_restore(status_restore));
   cpirq_seq_model cpirq_seq_model_i (
      .clock(clock), .sys_rst(sys_rst), .slow(slow), .irq_out(irq_out),
      .irq_accept(irq_accept), .irq_return(irq_return));
   always #10 clock = ~clock;
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // one register access, strobe held for exactly one rising edge
   task automatic reg_acc(input logic [3:0] i, input logic w,
                          input logic [15:0] d);
      @(negedge clock);
      req = '{wr: w, rd: !w, idx: i, wdata: d};
      @(negedge clock);
      req = '0;
   endtask : reg_acc
   task automatic wr(input logic [3:0] i, input logic [15:0] d);
      reg_acc(i, 1'b1, d);
      regs[i] = d;
   endtask : wr
   task automatic rd(input logic [3:0] i, input logic [15:0] e);
      reg_acc(i, 1'b0, 16'h0000);
      check(32'(reg_rdata), 32'(e));
   endtask : rd
   // s = {power-down, soft reset, global disable, global enable}
   task automatic pulse(input logic [31:0] p, input logic [3:0] s);
      @(negedge clock);
      periph_irq = p;
      {pwrdn_irq, soft_reset_irq, gdis_i, gen_i} = s;
      @(negedge clock);
      periph_irq = '0;
      {pwrdn_irq, soft_reset_irq, gdis_i, gen_i} = 4'h0;
   endtask : pulse
   // bounded waits: a lost request must not hang the run
   task automatic take(input int idx);
      int n;
      n = 0;
      while (irq_out.valid !== 1'b1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      check(32'(irq_out.valid), 32'h0000_0001);
      check(32'(irq_out.index), 32'(idx));
      check(32'(irq_out.vector), 32'(idx * 32));
      n = 0;
      while (irq_return !== 1'b1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      // a handler that never ends counts as a mismatch
      check(32'(n < 20), 32'h0000_0001);
      @(negedge clock);
   endtask : take
   // looked at every cycle: a false request is accepted and gone quickly
   task automatic none;
      repeat (6) begin
         @(negedge clock);
         check(32'(irq_out.valid), 32'h0000_0000);
      end
   endtask : none
   task automatic wrap_up;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   // watchdog, far beyond the several hundred cycles the run needs
   initial begin
      #(20 * 20000);
      failures++;
      wrap_up();
   end
   initial begin
      {clock, emu_irq, soft_reset_irq, pwrdn_irq, gen_i, gdis_i} = '0;
      {slow, pc_push, pc_pop, loop_push, loop_pop, kern, periph_irq, req} = '0;
      {core_pc, core_status, failures, num_checks} = '0;
      seed = 77;
      sys_rst = 1'b1;
      for (k = 0; k < 16; k++) regs[k] = k >= 8 ? cpirq_pkg::RST_ROUTE : 0;
      repeat (5) @(negedge clock);
      sys_rst = 1'b0;
      reg_acc(4'h5, 1'b1, 16'h1234);   // unused index, write ignored
      for (k = 0; k < 16; k++) rd(4'(k), 16'(regs[k]));
      wr(4'h0, 16'hFFF0);
      pulse(32'h0000_0000, 4'h1);
      pulse(32'hFFFF_FFFF, 4'h0);
      none();
      // random sources and codes, both answer speeds
      for (k = 0; k < 24; k++) begin
         src = {$random(seed)} % 32;
         code = {$random(seed)} % 16;
         slow = 1'($random(seed));
         emu_irq = 1'($random(seed));
         core_status = 16'($random(seed));
         wr(4'(8 + src / 4),
            16'(32'h0000_FFFF ^ ((15 - code) << (4 * (src % 4)))));
         rd(4'(8 + src / 4), 16'(regs[8 + src / 4]));
         check(32'(emu_request), 32'(emu_irq));
         pulse(32'h0000_0001 << src, 4'h0);
         if (code <= 11) begin
            take(4 + code);
            check(32'(status_restore), 32'(core_status));
         end else begin
            none();
         end
      end
      // shared slot, masking and fixed priority
      wr(4'h8, 16'hF252);
      wr(4'h0, 16'h0200);
      // source 0 shares slot 2 with source 2, which is left idle
      pulse(32'h0000_0003, 4'h0);
      take(9);
      rd(4'h1, 16'h0040);
      pulse(32'h0000_0002, 4'h2);
      wr(4'h0, 16'h0240);
      none();
      pulse(32'h0000_0000, 4'h1);
      take(6);
      take(9);
      // software force and clear of latch bits
      wr(4'h0, 16'h0100);
      wr(4'h1, 16'h0100);
      take(8);
      pulse(32'h0000_0000, 4'h2);
      wr(4'h1, 16'h0080);
      rd(4'h1, 16'h0080);
      wr(4'h1, 16'h0000);
      rd(4'h1, 16'h0000);
      // reset passes global disable, power-down waits for enable
      wr(4'h0, 16'h0000);
      pulse(32'h0000_0000, 4'h4);
      take(0);
      pulse(32'h0000_0000, 4'h8);
      none();
      pulse(32'h0000_0000, 4'h1);
      take(1);
      // kernel request is maskable
      slow = 1'b0;
      wr(4'h0, 16'h0038);
      @(negedge clock);
      kern = 1'b1;
      @(negedge clock);
      kern = 1'b0;
      take(3);
      // nesting on: slot 0 must be offered while slot 1 is running
      wr(4'h2, 16'h0021);
      rd(4'h2, 16'h0021);
      wr(4'h1, 16'h0020);
      wr(4'h1, 16'h0010);
      @(negedge clock);
      check(32'(irq_out.valid), 32'h0000_0001);
      take(4);
      none();
      // fill both stacks past full, then drain below the low mark
      {pc_push, loop_push} = 2'b11;
      for (k = 0; k < 34; k++) begin
         core_pc = 24'(k);
         @(negedge clock);
      end
      {pc_push, loop_push} = 2'b00;
      rd(4'h3, 16'((cpirq_pkg::LOOP_LEVELS << 6) |
                   cpirq_pkg::PC_LEVELS));
      rd(4'h1, 16'h0004);
      pulse(32'h0000_0000, 4'h0);
      wr(4'h1, 16'h0000);
      {pc_pop, loop_pop} = 2'b11;
      @(negedge clock);
      {pc_pop, loop_pop} = 2'b00;
      @(negedge clock);
      check(32'(pc_top), 32'h0000_0020);
      check(32'(loop_top), 32'h0000_0007);
      pc_pop = 1'b1;
      repeat (30) @(negedge clock);
      pc_pop = 1'b0;
      rd(4'h1, 16'h0004);
      wrap_up();
   end
endmodule : core_and_peripheral_irq_router_test
